// ==== bench/rtec_top_test.sv ====
// Self-checking testbench for the bus latency and retirement tag counter block
module rtec_top_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic        wr_i = 1'b0, rd_i = 1'b0;
    logic        busq_alloc_i = 1'b0, busq_alloc_full_i = 1'b0, busq_alloc_inacc_i = 1'b0;
    logic        l2_wb_i = 1'b0, busq_dealloc_i = 1'b0, busq_dealloc_full_i = 1'b0;
    logic        arb_slot_i = 1'b0, demand_req_i = 1'b0, adj_req_i = 1'b0;
    logic        early_valid_i = 1'b0, early_load_i = 1'b0, early_store_i = 1'b0;
    logic        early_split_i = 1'b0, early_untaggable_i = 1'b0;
    logic [2:0]  early_class_i = 3'h0;
    logic        ret_valid_i = 1'b0, ret_bogus_i = 1'b0, ret_replay_tag_i = 1'b0;
    logic        ret_fe_tag_i = 1'b0, fp_stack_fault_i = 1'b0;
    logic [3:0]  ret_exec_tag_i = 4'h0;
    logic [31:0] rdata_o;
    logic        grant_demand_o, grant_adj_o, replay_tag_o, fe_tag_o;
    logic [3:0]  exec_tag_o;
    int          n_errors = 0;
    int          num_checks = 0;

    rtec_top rtec_top_i (
        .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .busq_alloc_i(busq_alloc_i),
        .busq_alloc_full_i(busq_alloc_full_i), .busq_alloc_inacc_i(busq_alloc_inacc_i),
        .l2_wb_i(l2_wb_i), .busq_dealloc_i(busq_dealloc_i),
        .busq_dealloc_full_i(busq_dealloc_full_i),
        .arb_slot_i(arb_slot_i), .demand_req_i(demand_req_i), .adj_req_i(adj_req_i),
        .grant_demand_o(grant_demand_o), .grant_adj_o(grant_adj_o),
        .early_valid_i(early_valid_i), .early_load_i(early_load_i),
        .early_store_i(early_store_i), .early_split_i(early_split_i),
        .early_untaggable_i(early_untaggable_i), .early_class_i(early_class_i),
        .replay_tag_o(replay_tag_o), .fe_tag_o(fe_tag_o), .exec_tag_o(exec_tag_o),
        .ret_valid_i(ret_valid_i), .ret_bogus_i(ret_bogus_i),
        .ret_replay_tag_i(ret_replay_tag_i), .ret_fe_tag_i(ret_fe_tag_i),
        .ret_exec_tag_i(ret_exec_tag_i), .fp_stack_fault_i(fp_stack_fault_i)
    );

    always #50 clock_i = ~clock_i;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // All tasks start just after a rising edge and return the same way
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
        // One idle edge so a following call never drives the strobe twice in a step
        @(posedge clock_i);
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
        @(posedge clock_i);
    endtask

    task automatic early(input logic ld, st, sp, un, input logic [2:0] cls,
                         input logic rt, ft, input logic [3:0] et);
        early_valid_i <= 1'b1;
        early_load_i <= ld;
        early_store_i <= st;
        early_split_i <= sp;
        early_untaggable_i <= un;
        early_class_i <= cls;
        @(posedge clock_i);
        early_valid_i <= 1'b0;
        #1;
        chk("replay_tag_o", {31'h0, rt}, {31'h0, replay_tag_o});
        chk("fe_tag_o", {31'h0, ft}, {31'h0, fe_tag_o});
        chk("exec_tag_o", {28'h0, et}, {28'h0, exec_tag_o});
        @(posedge clock_i);
    endtask

    task automatic retire(input logic bg, rtg, ftg, input logic [3:0] etg);
        ret_valid_i <= 1'b1;
        ret_bogus_i <= bg;
        ret_replay_tag_i <= rtg;
        ret_fe_tag_i <= ftg;
        ret_exec_tag_i <= etg;
        @(posedge clock_i);
        ret_valid_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic arb(input logic dem, adj, input logic gd, ga);
        arb_slot_i <= 1'b1;
        demand_req_i <= dem;
        adj_req_i <= adj;
        @(posedge clock_i);
        arb_slot_i <= 1'b0;
        #1;
        chk("grant_demand_o", {31'h0, gd}, {31'h0, grant_demand_o});
        chk("grant_adj_o", {31'h0, ga}, {31'h0, grant_adj_o});
        @(posedge clock_i);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run is about a hundred cycles; this leaves a wide margin
    initial begin
        repeat (5000) @(posedge clock_i);
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        reg_chk("exec_up reset", rtec_pkg::OFS_EXEC_UP, rtec_pkg::RST_EXEC_UP);
        reg_chk("tag_en reset", rtec_pkg::OFS_TAG_EN, rtec_pkg::RST_ZERO);
        reg_chk("unmapped", 8'h3c, 32'h0000_0000);
        reg_wr(rtec_pkg::OFS_UNDERWAY, 32'h0000_00ff);
        reg_chk("underway ro", rtec_pkg::OFS_UNDERWAY, 32'h0000_0000);
        $display("test reset_and_map done");
        // Full line held for four edges: two units each edge
        busq_alloc_i <= 1'b1;
        busq_alloc_full_i <= 1'b1;
        @(posedge clock_i);
        busq_alloc_i <= 1'b0;
        busq_alloc_full_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        busq_dealloc_i <= 1'b1;
        busq_dealloc_full_i <= 1'b1;
        @(posedge clock_i);
        busq_dealloc_i <= 1'b0;
        busq_dealloc_full_i <= 1'b0;
        reg_chk("underway", rtec_pkg::OFS_UNDERWAY, 32'h0000_0008);
        reg_chk("allocs", rtec_pkg::OFS_ALLOCS, 32'h0000_0002);
        l2_wb_i <= 1'b1;
        @(posedge clock_i);
        l2_wb_i <= 1'b0;
        reg_chk("allocs no l3", rtec_pkg::OFS_ALLOCS, 32'h0000_0002);
        reg_wr(rtec_pkg::OFS_CFG, 32'h0000_0001);
        l2_wb_i <= 1'b1;
        @(posedge clock_i);
        l2_wb_i <= 1'b0;
        reg_chk("allocs l3", rtec_pkg::OFS_ALLOCS, 32'h0000_0003);
        busq_alloc_i <= 1'b1;
        busq_alloc_inacc_i <= 1'b1;
        @(posedge clock_i);
        busq_alloc_i <= 1'b0;
        busq_alloc_inacc_i <= 1'b0;
        reg_chk("status occ flag", rtec_pkg::OFS_STATUS, 32'h0000_0201);
        busq_dealloc_i <= 1'b1;
        busq_dealloc_full_i <= 1'b1;
        @(posedge clock_i);
        busq_dealloc_i <= 1'b0;
        busq_dealloc_full_i <= 1'b0;
        reg_wr(rtec_pkg::OFS_STATUS, 32'h0000_0001);
        fp_stack_fault_i <= 1'b1;
        @(posedge clock_i);
        fp_stack_fault_i <= 1'b0;
        reg_chk("status fe flag", rtec_pkg::OFS_STATUS, 32'h0000_0002);
        reg_wr(rtec_pkg::OFS_STATUS, 32'h0000_0002);
        reg_chk("status fe clear", rtec_pkg::OFS_STATUS, 32'h0000_0000);
        $display("test bus_queue done");
        arb(1'b1, 1'b1, 1'b1, 1'b0);
        arb(1'b0, 1'b1, 1'b0, 1'b1);
        $display("test arbiter done");
        early(1'b1, 1'b0, 1'b1, 1'b0, 3'h3, 1'b0, 1'b0, 4'h0);
        reg_wr(rtec_pkg::OFS_TAG_EN, 32'h0300_0400);
        early(1'b1, 1'b0, 1'b1, 1'b0, 3'h3, 1'b0, 1'b0, 4'h0);
        reg_wr(rtec_pkg::OFS_MATRIX, 32'h0000_0001);
        reg_wr(rtec_pkg::OFS_LDPORT, 32'h0000_0031);
        reg_wr(rtec_pkg::OFS_UOPTYPE, 32'h0000_0005);
        reg_wr(rtec_pkg::OFS_EXEC_UP, 32'h0000_003b);
        early(1'b1, 1'b0, 1'b1, 1'b0, 3'h3, 1'b1, 1'b1, 4'h1);
        early(1'b1, 1'b0, 1'b1, 1'b1, 3'h3, 1'b0, 1'b0, 4'h0);
        early(1'b0, 1'b1, 1'b0, 1'b0, 3'h2, 1'b0, 1'b0, 4'h0);
        reg_wr(rtec_pkg::OFS_UOPTYPE, 32'h0000_0006);
        early(1'b0, 1'b1, 1'b0, 1'b0, 3'h2, 1'b0, 1'b1, 4'h0);
        $display("test tagging done");
        reg_wr(rtec_pkg::OFS_EXEC_DN, 32'h0000_0001);
        reg_wr(rtec_pkg::OFS_INSTR, 32'h0000_0001);
        retire(1'b0, 1'b1, 1'b1, 4'h1);
        retire(1'b1, 1'b1, 1'b1, 4'h1);
        retire(1'b0, 1'b0, 1'b0, 4'h2);
        reg_wr(rtec_pkg::OFS_INSTR, 32'h0000_0002);
        retire(1'b1, 1'b0, 1'b0, 4'h0);
        reg_wr(rtec_pkg::OFS_REPLAY_CN, 32'h0000_0055);
        reg_chk("replay cnt", rtec_pkg::OFS_REPLAY_CN, 32'h0000_0001);
        reg_chk("fe cnt", rtec_pkg::OFS_FE_CN, 32'h0000_0001);
        reg_chk("exec cnt", rtec_pkg::OFS_EXEC_CN, 32'h0000_0001);
        reg_chk("instr cnt", rtec_pkg::OFS_INSTR_CN, 32'h0000_0003);
        $display("test retirement done");
        wrap_up();
    end
endmodule // rtec_top_test

// ==== design/rtec_pkg.sv ====
// Constants for the retirement tag and bus latency counter block
// Overview of operation
// [RQ1] Sum active bus queue entries every cycle
// [RQ2] Entry released only when transaction fully done
// [RQ3] Demand fetch beats adjacent half prefetch
// [RQ4] Allocations counted in 64-byte units
// [RQ5] Level-two writebacks allocate entries with level-three
// [RQ6] Flag uncached chunk and partial combining entries
// [RQ7] Count only with tag and event both set
// [RQ8] Replay tag needs enable and matrix bits
// [RQ9] Split loads: bits 10,24,25 plus port select
// [RQ10] Never tag untaggable operation kinds
// [RQ11] Load tag bit tags front-end loads
// [RQ12] Store tag bit tags front-end stores
// [RQ13] Stack faults flag possible front-end undercount
// [RQ14] Upstream select marks, downstream counts retired
// [RQ15] All bit, tag enable, value one, non-bogus
// [RQ16] Completion counts non-bogus or bogus per mask
// [RQ17] Counters add per event, read without disturbance
package rtec_pkg;
    localparam logic [7:0] OFS_TAG_EN    = 8'h00;
    localparam logic [7:0] OFS_MATRIX    = 8'h04;
    localparam logic [7:0] OFS_LDPORT    = 8'h08;
    localparam logic [7:0] OFS_UOPTYPE   = 8'h0c;
    localparam logic [7:0] OFS_EXEC_UP   = 8'h10;
    localparam logic [7:0] OFS_EXEC_DN   = 8'h14;
    localparam logic [7:0] OFS_INSTR     = 8'h18;
    localparam logic [7:0] OFS_CFG       = 8'h1c;
    localparam logic [7:0] OFS_UNDERWAY  = 8'h20;
    localparam logic [7:0] OFS_ALLOCS    = 8'h24;
    localparam logic [7:0] OFS_STATUS    = 8'h28;
    localparam logic [7:0] OFS_REPLAY_CN = 8'h2c;
    localparam logic [7:0] OFS_FE_CN     = 8'h30;
    localparam logic [7:0] OFS_EXEC_CN   = 8'h34;
    localparam logic [7:0] OFS_INSTR_CN  = 8'h38;
    localparam int TAG_SPLIT_BIT  = 10;
    localparam int TAG_RET_A_BIT  = 24;
    localparam int TAG_RET_B_BIT  = 25;
    localparam int MATRIX_LD_BIT  = 0;
    localparam int LDP_EVT_LSB    = 0;
    localparam int LDP_EVT_W      = 4;
    localparam logic [3:0] LDP_EVT_PORT_REPLAY = 4'h1;
    localparam int LDP_SPLIT_BIT  = 4;
    localparam int LDP_NONSPEC_BIT = 5;
    localparam int UT_LOAD_BIT    = 0;
    localparam int UT_STORE_BIT   = 1;
    localparam int UT_NONSPEC_BIT = 2;
    localparam int EU_CLASS_LSB   = 0;
    localparam int EU_CLASS_W     = 3;
    localparam int EU_ALL_BIT     = 3;
    localparam int EU_TAGEN_BIT   = 4;
    localparam int EU_VAL_LSB     = 5;
    localparam int EU_VAL_W       = 4;
    localparam int ED_NONSPEC_BIT = 0;
    localparam int IN_NONSPEC_BIT = 0;
    localparam int IN_BOGUS_BIT   = 1;
    localparam int CFG_L3_BIT     = 0;
    localparam int ST_UNREL_BIT   = 0;
    localparam int ST_FEUND_BIT   = 1;
    localparam int ST_OCC_LSB     = 8;
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic [31:0] RST_EXEC_UP = 32'h0000_0020;
endpackage

// ==== design/rtec_top.sv ====
// Bus queue latency accumulators and retirement tag counters
module rtec_top #(
    parameter int ENTRIES = 8,
    parameter int CNT_W   = 32
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        busq_alloc_i,
    input  wire logic        busq_alloc_full_i,
    input  wire logic        busq_alloc_inacc_i,
    input  wire logic        l2_wb_i,
    input  wire logic        busq_dealloc_i,
    input  wire logic        busq_dealloc_full_i,
    input  wire logic        arb_slot_i,
    input  wire logic        demand_req_i,
    input  wire logic        adj_req_i,
    output logic             grant_demand_o,
    output logic             grant_adj_o,
    input  wire logic        early_valid_i,
    input  wire logic        early_load_i,
    input  wire logic        early_store_i,
    input  wire logic        early_split_i,
    input  wire logic        early_untaggable_i,
    input  wire logic [2:0]  early_class_i,
    output logic             replay_tag_o,
    output logic             fe_tag_o,
    output logic      [3:0]  exec_tag_o,
    input  wire logic        ret_valid_i,
    input  wire logic        ret_bogus_i,
    input  wire logic        ret_replay_tag_i,
    input  wire logic        ret_fe_tag_i,
    input  wire logic [3:0]  ret_exec_tag_i,
    input  wire logic        fp_stack_fault_i
);
    localparam int OCC_W = $clog2(2 * ENTRIES + 4);

    initial begin
        if (ENTRIES < 1 || ENTRIES > 64 || CNT_W < 8 || CNT_W > 32) begin
            $error("rtec_top: unsupported ENTRIES or CNT_W");
        end
    end

    // Weight in 64-byte units so allocations match active-entry granularity
    function automatic logic [1:0] unit_w(input logic v, input logic full);
        unit_w = v ? (full ? 2'h2 : 2'h1) : 2'h0;
    endfunction

    logic [31:0]      tag_en_r;
    logic [31:0]      matrix_r;
    logic [31:0]      ldport_r;
    logic [31:0]      uoptype_r;
    logic [31:0]      exec_up_r;
    logic [31:0]      exec_dn_r;
    logic [31:0]      instr_r;
    logic [31:0]      cfg_r;
    logic [OCC_W-1:0] occ_r;
    logic [CNT_W-1:0] underway_r;
    logic [CNT_W-1:0] allocs_r;
    logic [CNT_W-1:0] replay_cn_r;
    logic [CNT_W-1:0] fe_cn_r;
    logic [CNT_W-1:0] exec_cn_r;
    logic [CNT_W-1:0] instr_cn_r;
    logic             unrel_r;
    logic             feund_r;

    wire wr_tag_en  = wr_i && addr_i == rtec_pkg::OFS_TAG_EN;
    wire wr_matrix  = wr_i && addr_i == rtec_pkg::OFS_MATRIX;
    wire wr_ldport  = wr_i && addr_i == rtec_pkg::OFS_LDPORT;
    wire wr_uoptype = wr_i && addr_i == rtec_pkg::OFS_UOPTYPE;
    wire wr_exec_up = wr_i && addr_i == rtec_pkg::OFS_EXEC_UP;
    wire wr_exec_dn = wr_i && addr_i == rtec_pkg::OFS_EXEC_DN;
    wire wr_instr   = wr_i && addr_i == rtec_pkg::OFS_INSTR;
    wire wr_cfg     = wr_i && addr_i == rtec_pkg::OFS_CFG;
    wire wr_status  = wr_i && addr_i == rtec_pkg::OFS_STATUS;

    // Writebacks hitting level three never reach the bus but still hold an entry
    wire       wb_alloc  = l2_wb_i && cfg_r[rtec_pkg::CFG_L3_BIT];                  // [RQ5]
    wire [1:0] alloc_w   = unit_w(busq_alloc_i, busq_alloc_full_i);                // [RQ4]
    wire [1:0] wb_w      = unit_w(wb_alloc, 1'b0);
    wire [1:0] dealloc_w = unit_w(busq_dealloc_i, busq_dealloc_full_i);            // [RQ2]
    wire [OCC_W-1:0] occ_up  = occ_r + OCC_W'(alloc_w) + OCC_W'(wb_w);
    wire [OCC_W-1:0] occ_nxt = (occ_up > OCC_W'(dealloc_w)) ? occ_up - OCC_W'(dealloc_w)
                                                            : '0;
    wire [CNT_W-1:0] underway_nxt = underway_r + CNT_W'(occ_r);                     // [RQ1]
    wire [CNT_W-1:0] allocs_nxt   = allocs_r + CNT_W'(alloc_w) + CNT_W'(wb_w);      // [RQ4]

    // Adjacent-half prefetch only takes a slot that no demand fetch wants
    wire grant_demand_nxt = arb_slot_i && demand_req_i;                             // [RQ3]
    wire grant_adj_nxt    = arb_slot_i && adj_req_i && !demand_req_i;               // [RQ3]

    wire taggable  = early_valid_i && !early_untaggable_i;                          // [RQ10]
    wire [3:0] ldp_evt = ldport_r[rtec_pkg::LDP_EVT_LSB +: rtec_pkg::LDP_EVT_W];
    wire replay_arm = tag_en_r[rtec_pkg::TAG_SPLIT_BIT]
                   && tag_en_r[rtec_pkg::TAG_RET_A_BIT]
                   && tag_en_r[rtec_pkg::TAG_RET_B_BIT]
                   && matrix_r[rtec_pkg::MATRIX_LD_BIT]
                   && ldp_evt == rtec_pkg::LDP_EVT_PORT_REPLAY
                   && ldport_r[rtec_pkg::LDP_SPLIT_BIT];                           // [RQ8] [RQ9]
    wire replay_tag_nxt = taggable && early_load_i && early_split_i && replay_arm;  // [RQ9]
    wire fe_ld_tag  = early_load_i && uoptype_r[rtec_pkg::UT_LOAD_BIT];             // [RQ11]
    wire fe_st_tag  = early_store_i && uoptype_r[rtec_pkg::UT_STORE_BIT];           // [RQ12]
    wire fe_tag_nxt = taggable && (fe_ld_tag || fe_st_tag);

    wire [2:0] eu_class = exec_up_r[rtec_pkg::EU_CLASS_LSB +: rtec_pkg::EU_CLASS_W];
    wire [3:0] eu_value = exec_up_r[rtec_pkg::EU_VAL_LSB +: rtec_pkg::EU_VAL_W];
    wire exec_hit = taggable && exec_up_r[rtec_pkg::EU_ALL_BIT]
                 && exec_up_r[rtec_pkg::EU_TAGEN_BIT] && early_class_i == eu_class; // [RQ14]
    wire [3:0] exec_tag_nxt = exec_hit ? eu_value : 4'h0;                          // [RQ15]

    // Tag alone is not enough: the retirement event must also be selected
    wire ret_good   = ret_valid_i && !ret_bogus_i;
    wire replay_inc = ret_good && ret_replay_tag_i
                   && ldport_r[rtec_pkg::LDP_NONSPEC_BIT];                         // [RQ7]
    wire fe_inc     = ret_good && ret_fe_tag_i
                   && uoptype_r[rtec_pkg::UT_NONSPEC_BIT];                         // [RQ11] [RQ12]
    wire exec_inc   = ret_good && eu_value != 4'h0 && ret_exec_tag_i == eu_value
                   && exec_dn_r[rtec_pkg::ED_NONSPEC_BIT];                         // [RQ14]
    wire instr_inc  = ret_valid_i
                   && ((instr_r[rtec_pkg::IN_NONSPEC_BIT] && !ret_bogus_i)
                    || (instr_r[rtec_pkg::IN_BOGUS_BIT] && ret_bogus_i));          // [RQ16]

    // Sticky flags: a new event in the clearing cycle keeps the flag set
    wire unrel_nxt = (busq_alloc_i && busq_alloc_inacc_i)
                  || (unrel_r && !(wr_status && wdata_i[rtec_pkg::ST_UNREL_BIT])); // [RQ6]
    wire feund_nxt = fp_stack_fault_i
                  || (feund_r && !(wr_status && wdata_i[rtec_pkg::ST_FEUND_BIT])); // [RQ13]

    wire [31:0] status_v = (32'(occ_r) << rtec_pkg::ST_OCC_LSB)
                         | (32'(feund_r) << rtec_pkg::ST_FEUND_BIT)
                         | (32'(unrel_r) << rtec_pkg::ST_UNREL_BIT);
    wire [31:0] rmux =
        addr_i == rtec_pkg::OFS_TAG_EN    ? tag_en_r :
        addr_i == rtec_pkg::OFS_MATRIX    ? matrix_r :
        addr_i == rtec_pkg::OFS_LDPORT    ? ldport_r :
        addr_i == rtec_pkg::OFS_UOPTYPE   ? uoptype_r :
        addr_i == rtec_pkg::OFS_EXEC_UP   ? exec_up_r :
        addr_i == rtec_pkg::OFS_EXEC_DN   ? exec_dn_r :
        addr_i == rtec_pkg::OFS_INSTR     ? instr_r :
        addr_i == rtec_pkg::OFS_CFG       ? cfg_r :
        addr_i == rtec_pkg::OFS_UNDERWAY  ? 32'(underway_r) :
        addr_i == rtec_pkg::OFS_ALLOCS    ? 32'(allocs_r) :
        addr_i == rtec_pkg::OFS_STATUS    ? status_v :
        addr_i == rtec_pkg::OFS_REPLAY_CN ? 32'(replay_cn_r) :
        addr_i == rtec_pkg::OFS_FE_CN     ? 32'(fe_cn_r) :
        addr_i == rtec_pkg::OFS_EXEC_CN   ? 32'(exec_cn_r) :
        addr_i == rtec_pkg::OFS_INSTR_CN  ? 32'(instr_cn_r) : 32'h0000_0000;
    wire [31:0] rdata_nxt = rd_i ? rmux : 32'h0000_0000;                           // [RQ17]

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tag_en_r  <= rtec_pkg::RST_ZERO;
            matrix_r  <= rtec_pkg::RST_ZERO;
            ldport_r  <= rtec_pkg::RST_ZERO;
            uoptype_r <= rtec_pkg::RST_ZERO;
            exec_up_r <= rtec_pkg::RST_EXEC_UP;
            exec_dn_r <= rtec_pkg::RST_ZERO;
            instr_r   <= rtec_pkg::RST_ZERO;
            cfg_r     <= rtec_pkg::RST_ZERO;
        end else begin
            if (wr_tag_en)  tag_en_r  <= wdata_i;
            if (wr_matrix)  matrix_r  <= wdata_i;
            if (wr_ldport)  ldport_r  <= wdata_i;
            if (wr_uoptype) uoptype_r <= wdata_i;
            if (wr_exec_up) exec_up_r <= wdata_i;
            if (wr_exec_dn) exec_dn_r <= wdata_i;
            if (wr_instr)   instr_r   <= wdata_i;
            if (wr_cfg)     cfg_r     <= wdata_i;
        end
    end

    // Counters wrap; software takes differences between reads
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            occ_r       <= '0;
            underway_r  <= '0;
            allocs_r    <= '0;
            replay_cn_r <= '0;
            fe_cn_r     <= '0;
            exec_cn_r   <= '0;
            instr_cn_r  <= '0;
            unrel_r     <= 1'b0;
            feund_r     <= 1'b0;
        end else begin
            occ_r       <= occ_nxt;
            underway_r  <= underway_nxt;
            allocs_r    <= allocs_nxt;
            replay_cn_r <= replay_cn_r + CNT_W'(replay_inc);                       // [RQ17]
            fe_cn_r     <= fe_cn_r + CNT_W'(fe_inc);
            exec_cn_r   <= exec_cn_r + CNT_W'(exec_inc);
            instr_cn_r  <= instr_cn_r + CNT_W'(instr_inc);
            unrel_r     <= unrel_nxt;
            feund_r     <= feund_nxt;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o        <= 32'h0000_0000;
            grant_demand_o <= 1'b0;
            grant_adj_o    <= 1'b0;
            replay_tag_o   <= 1'b0;
            fe_tag_o       <= 1'b0;
            exec_tag_o     <= 4'h0;
        end else begin
            rdata_o        <= rdata_nxt;
            grant_demand_o <= grant_demand_nxt;
            grant_adj_o    <= grant_adj_nxt;
            replay_tag_o   <= replay_tag_nxt;
            fe_tag_o       <= fe_tag_nxt;
            exec_tag_o     <= exec_tag_nxt;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    adj_yields_a: assert property (arb_slot_i && demand_req_i |=> !grant_adj_o) // [RQ3]
        else $error("adjacent prefetch took a demand slot");
    adj_granted_a: assert property (
        arb_slot_i && adj_req_i && !demand_req_i |=> grant_adj_o && !grant_demand_o) // [RQ3]
        else $error("free slot not given to adjacent prefetch");
    underway_sum_a: assert property (
        ##1 underway_r == $past(underway_r) + CNT_W'($past(occ_r))) // [RQ1]
        else $error("underway sum missed active entries");
    entry_held_a: assert property (
        !busq_alloc_i && !wb_alloc && !busq_dealloc_i |=> occ_r == $past(occ_r)) // [RQ2]
        else $error("entry count moved without alloc or release");
    full_weight_a: assert property (
        busq_alloc_i && busq_alloc_full_i && !wb_alloc
        |=> allocs_r == $past(allocs_r) + CNT_W'(2)) // [RQ4]
        else $error("full line allocation not counted as two units");
    wb_alloc_a: assert property (
        l2_wb_i && cfg_r[rtec_pkg::CFG_L3_BIT] && !busq_alloc_i && !busq_dealloc_i
        |=> occ_r == $past(occ_r) + OCC_W'(1)) // [RQ5]
        else $error("writeback did not allocate an entry");
    unrel_flag_a: assert property (busq_alloc_i && busq_alloc_inacc_i |=> unrel_r) // [RQ6]
        else $error("unreliable category not flagged");
    no_tag_a: assert property (
        early_valid_i && early_untaggable_i
        |=> !replay_tag_o && !fe_tag_o && exec_tag_o == 4'h0) // [RQ10]
        else $error("untaggable operation was tagged");
    split_tag_a: assert property (
        replay_tag_o |-> $past(replay_arm) && $past(early_split_i)) // [RQ9]
        else $error("replay tag without full split load setup");
    replay_cnt_a: assert property (
        replay_inc |=> replay_cn_r == $past(replay_cn_r) + CNT_W'(1)) // [RQ7]
        else $error("tagged retirement not counted");
    instr_cnt_a: assert property (
        ret_valid_i && ret_bogus_i && !instr_r[rtec_pkg::IN_BOGUS_BIT]
        |=> instr_cn_r == $past(instr_cn_r)) // [RQ16]
        else $error("bogus retirement counted without bogus mask");
    exec_tag_a: assert property (
        exec_hit |=> exec_tag_o == $past(eu_value)) // [RQ15]
        else $error("execution tag value not applied");
    fe_under_a: assert property (fp_stack_fault_i |=> feund_r) // [RQ13]
        else $error("stack fault not flagged");
    rdata_once_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000) // [RQ17]
        else $error("read data outside read answer cycle");
endmodule // rtec_top
